/* thermal_event_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the design file and the testbench only
`ifndef THERMAL_EVENT_REGS_SVH
`define THERMAL_EVENT_REGS_SVH
`define OFS_CFG1 8'h01
`define OFS_CFG2 8'h02
`define OFS_CFG4 8'h04
`define OFS_CONV_RATE 8'h05
`define OFS_FAULT_QUEUE 8'h06
`define OFS_MASK2 8'h09
`define OFS_PCT_LIMIT 8'h19
`define OFS_HYST 8'h1A
`define OFS_PCT_MEASURED 8'h4E
`define OFS_STATUS1 8'h4F
`define OFS_STATUS2 8'h50
`define CFG1_PIN_INPUT 2
`define CFG1_COMP_MODE 3
`define CFG2_BOOST_DIS 1
`define CFG4_REF_SEL 7
`define MASK2_PCT 4
`define STATUS2_PCT 4
`define RST_CONV_RATE 8'h07
`define RST_ZERO 8'h00
`define CONV_RATE_MAX 8'h0A
`define CONV_RATE_AVG_LIMIT 8'h08
`define CLK_HZ 100000000
// quarter-second window base, in ms as printed, and cycles derived from the rate
`define WIN_BASE_MS 250
`define WIN_BASE_CYC (`CLK_HZ / 1000 * `WIN_BASE_MS)
`define WIN_CODE_MAX 3'h5
`endif

/* thermal_event_pkg.sv */
// types shared by the thermal event block
// assumes nothing of its surroundings
package thermal_event_pkg;
	typedef enum logic [0:0] {
		CYC_IDLE = 1'b0,
		CYC_RUN = 1'b1
	} cycle_state_t;
endpackage

/* thermal_event_fault_queue_timer.sv */
// fault queues, conversion rate, overtemp pin io timer and fan stall pin
// assumes a register port driven by an smbus front end in this clock domain
//
// Contract
// [RL1] assert fan stall when either fan stalls
// [RL2] shared pin defaults stall; bit7 makes reference
// [RL3] queue filters temperature only, alert mode only
// [RL4] three channel queues; alert on full queue
// [RL5] queue depth decoded by highest set bit
// [RL6] queue counting ignores status flag values
// [RL7] ara, status read or reset empty queues
// [RL8] queue reset releases alert; refill reasserts
// [RL9] rate code selects 0.0625 times two power
// [RL10] averaging only below sixteen conversions/second
// [RL11] new rate waits for round robin end
// [RL12] pin low above limit, released below hysteresis
// [RL13] pin is output after power up
// [RL14] overtemp boosts fans unless boost disabled
// [RL15] cfg1 bit2 makes pin input only
// [RL16] low time measured as window percentage
// [RL17] window codes 0.25 s up to 8 s
// [RL18] excess sets status bit, alerts unless masked
// [RL19] limit 00 alerts first assertion; FF never
// [RL20] limit is eight bit, 0.39 percent step
// [RL21] compare once the window has elapsed
// [RL22] cfg4 bits 0..2 let events drive pin
// [RL23] cfg1 bit3 selects latched or comparator alert
// [RL24] mask2 bit4 hides percentage alert only
`timescale 1ns/1ps
`include "thermal_event_regs.svh"

module thermal_event_fault_queue_timer
	import thermal_event_pkg::*;
#(
	parameter int unsigned WIN_BASE_CYCLES = `WIN_BASE_CYC
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic ARA_DONE,
	input wire logic RESULT_VALID,
	input wire logic [1:0] RESULT_CHAN,
	input wire logic RESULT_OUT_OF_LIMIT,
	input wire logic ROUND_ROBIN_END,
	input wire logic [2:0] OVERTEMP_ABOVE,
	input wire logic [2:0] OVERTEMP_BELOW_HYST,
	input wire logic [1:0] FAN_STALLED,
	input wire logic OVERTEMP_PIN_IN,
	output logic OVERTEMP_PIN_OUT,
	output logic OVERTEMP_PIN_OE,
	output logic FAN_STALL_PIN_OUT,
	output logic FAN_STALL_PIN_OE,
	output logic REF_INPUT_SEL,
	output logic ALERT_QUEUED,
	output logic PCT_ALERT,
	output logic FAN_BOOST,
	output logic [7:0] ACTIVE_CONV_RATE,
	output logic AVERAGING_ON
);
	typedef struct packed {
		logic [7:0] cfg1, cfg2, cfg4, conv_rate, fault_queue, mask2, pct_limit, hyst;
		logic [7:0] pct_measured, status1, status2;
		logic [2:0][2:0] queue_cnt;
		logic [2:0] chan_full;
		logic [2:0] overtemp_hot;
		cycle_state_t cyc;
		logic [7:0] active_rate;
		logic [31:0] win_cnt;
		logic [31:0] low_cnt;
		logic seen_low;
		logic [7:0] rdata;
		logic pin_out, pin_oe, stall_out, stall_oe, ref_sel, alert_q, pct_alert, boost, avg;
	} state_t;

	state_t s_q, s_d;
	logic [1:0] rst_sync_q;
	logic rst_n;

	// queue depth with priority on highest set bit
	function automatic logic [2:0] queue_depth(input logic [7:0] v);
		if (v[3]) begin
			return 3'h4;
		end else if (v[2]) begin
			return 3'h3;
		end else if (v[1]) begin
			return 3'h2;
		end
		return 3'h1;
	endfunction

	// window length in cycles: base doubled per code, codes above 4 all 8 s
	function automatic logic [31:0] window_cycles(input logic [2:0] code);
		logic [2:0] c;
		c = (code > `WIN_CODE_MAX) ? `WIN_CODE_MAX : code;
		return 32'(WIN_BASE_CYCLES) << c;
	endfunction

	assign rst_n = rst_sync_q[1];

	// register next state
	always_comb begin
		logic [31:0] win_len;
		logic [39:0] pct_wide;
		logic [7:0] pct;
		logic queue_clear;
		logic [2:0] depth;
		logic pin_event;
		win_len = '0;
		pct_wide = '0;
		pct = '0;
		queue_clear = 1'b0;
		depth = '0;
		pin_event = 1'b0;
		s_d = s_q;
		// host writes
		if (REG_WR) begin
			case (REG_ADDR)
				`OFS_CFG1: s_d.cfg1 = REG_WDATA;
				`OFS_CFG2: s_d.cfg2 = REG_WDATA;
				`OFS_CFG4: s_d.cfg4 = REG_WDATA;
				`OFS_CONV_RATE: s_d.conv_rate = REG_WDATA;
				`OFS_FAULT_QUEUE: s_d.fault_queue = REG_WDATA;
				`OFS_MASK2: s_d.mask2 = REG_WDATA;
				`OFS_PCT_LIMIT: s_d.pct_limit = REG_WDATA; // [RL20]
				`OFS_HYST: s_d.hyst = REG_WDATA;
				default: ;
			endcase
		end
		// read data, registered one cycle after the strobe
		case (REG_ADDR)
			`OFS_CFG1: s_d.rdata = s_q.cfg1;
			`OFS_CFG2: s_d.rdata = s_q.cfg2;
			`OFS_CFG4: s_d.rdata = s_q.cfg4;
			`OFS_CONV_RATE: s_d.rdata = s_q.conv_rate;
			`OFS_FAULT_QUEUE: s_d.rdata = s_q.fault_queue;
			`OFS_MASK2: s_d.rdata = s_q.mask2;
			`OFS_PCT_LIMIT: s_d.rdata = s_q.pct_limit;
			`OFS_HYST: s_d.rdata = s_q.hyst;
			`OFS_PCT_MEASURED: s_d.rdata = s_q.pct_measured;
			`OFS_STATUS1: s_d.rdata = s_q.status1;
			`OFS_STATUS2: s_d.rdata = s_q.status2;
			default: s_d.rdata = 8'h00;
		endcase
		// status 1 read or completed ara empties queues
		queue_clear = ARA_DONE || (REG_RD && REG_ADDR == `OFS_STATUS1); // [RL7]
		if (REG_RD && REG_ADDR == `OFS_STATUS1) begin
			s_d.status1 = 8'h00;
		end
		if (REG_RD && REG_ADDR == `OFS_STATUS2) begin
			s_d.status2 = 8'h00;
		end
		// per-channel consecutive count; status bits play no part
		// comparator mode bypasses the queue: one reading sets, one in-limit reading clears
		depth = s_q.cfg1[`CFG1_COMP_MODE] ? 3'h1 : queue_depth(s_q.fault_queue); // [RL3] [RL5]
		if (queue_clear) begin
			s_d.queue_cnt = '0; // [RL8]
			s_d.chan_full = '0;
		end
		if (RESULT_VALID && RESULT_CHAN < 2'h3) begin
			if (RESULT_OUT_OF_LIMIT) begin
				s_d.status1[RESULT_CHAN] = 1'b1; // set wins over the read clear
				if (s_d.queue_cnt[RESULT_CHAN] < depth) begin
					s_d.queue_cnt[RESULT_CHAN] = s_d.queue_cnt[RESULT_CHAN] + 3'h1; // [RL4] [RL6]
				end
				if (s_d.queue_cnt[RESULT_CHAN] >= depth) begin
					s_d.chan_full[RESULT_CHAN] = 1'b1;
				end
			end else begin
				s_d.queue_cnt[RESULT_CHAN] = '0;
				if (s_q.cfg1[`CFG1_COMP_MODE]) begin
					s_d.chan_full[RESULT_CHAN] = 1'b0;
				end
			end
		end
		// alert follows the queues; only comparator mode lets an in-limit reading drop it
		s_d.alert_q = |s_d.chan_full; // [RL3] [RL8] [RL23]
		// conversion rate swaps only at the end of the round robin loop
		case (s_q.cyc)
			CYC_IDLE: begin
				s_d.cyc = CYC_RUN;
			end
			CYC_RUN: begin
				if (ROUND_ROBIN_END && s_q.conv_rate <= `CONV_RATE_MAX) begin
					s_d.active_rate = s_q.conv_rate; // [RL9] [RL11]
				end
			end
			default: s_d.cyc = CYC_IDLE;
		endcase
		s_d.avg = s_q.active_rate < `CONV_RATE_AVG_LIMIT; // [RL10]
		// overtemp pin: assert above limit, hold until below limit minus hysteresis
		for (int i = 0; i < 3; i++) begin
			if (OVERTEMP_ABOVE[i]) begin
				s_d.overtemp_hot[i] = 1'b1; // [RL12]
			end else if (OVERTEMP_BELOW_HYST[i]) begin
				s_d.overtemp_hot[i] = 1'b0;
			end
		end
		if (s_q.cfg1[`CFG1_PIN_INPUT]) begin
			pin_event = |(s_q.overtemp_hot & s_q.cfg4[2:0]); // [RL15] [RL22]
		end else begin
			pin_event = |s_q.overtemp_hot; // [RL13]
		end
		s_d.pin_oe = pin_event;
		s_d.pin_out = 1'b0;
		s_d.boost = (|s_q.overtemp_hot) && !s_q.cfg2[`CFG2_BOOST_DIS]; // [RL14]
		// shared fan stall / reference pin, open drain low on stall
		s_d.ref_sel = s_q.cfg4[`CFG4_REF_SEL]; // [RL2]
		s_d.stall_oe = !s_q.cfg4[`CFG4_REF_SEL] && (|FAN_STALLED); // [RL1]
		s_d.stall_out = 1'b0;
		// low-time window measurement, only while the pin is an input
		win_len = window_cycles(s_q.cfg4[6:4]); // [RL17]
		if (s_q.cfg1[`CFG1_PIN_INPUT]) begin
			if (!OVERTEMP_PIN_IN) begin
				s_d.low_cnt = s_q.low_cnt + 32'h1; // [RL16]
				if (s_q.pct_limit == 8'h00 && !s_q.seen_low) begin
					s_d.status2[`STATUS2_PCT] = 1'b1; // [RL19]
				end
				s_d.seen_low = 1'b1;
			end
			s_d.win_cnt = s_q.win_cnt + 32'h1;
			if (s_q.win_cnt + 32'h1 >= win_len) begin
				pct_wide = ({8'h00, s_q.low_cnt} * 40'hFF) / {8'h00, win_len};
				pct = (pct_wide > 40'hFF) ? 8'hFF : pct_wide[7:0];
				s_d.pct_measured = pct;
				if (pct > s_q.pct_limit && s_q.pct_limit != 8'hFF) begin
					s_d.status2[`STATUS2_PCT] = 1'b1; // [RL18] [RL21]
				end
				s_d.win_cnt = '0;
				s_d.low_cnt = '0;
				s_d.seen_low = 1'b0;
			end
		end else begin
			s_d.win_cnt = '0;
			s_d.low_cnt = '0;
			s_d.seen_low = 1'b0;
		end
		s_d.pct_alert = s_d.status2[`STATUS2_PCT] && !s_q.mask2[`MASK2_PCT]; // [RL24]
	end

	// two-flop reset release, kept apart from the state record since it alone sees the raw reset
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	// remaining state on the released reset
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			s_q.cfg1 <= `RST_ZERO; // [RL13]
			s_q.cfg2 <= `RST_ZERO;
			s_q.cfg4 <= `RST_ZERO; // [RL2]
			s_q.conv_rate <= `RST_CONV_RATE;
			s_q.fault_queue <= `RST_ZERO;
			s_q.mask2 <= `RST_ZERO;
			s_q.pct_limit <= `RST_ZERO;
			s_q.hyst <= `RST_ZERO;
			s_q.pct_measured <= `RST_ZERO;
			s_q.status1 <= `RST_ZERO;
			s_q.status2 <= `RST_ZERO;
			s_q.queue_cnt <= '0; // [RL7]
			s_q.chan_full <= '0;
			s_q.overtemp_hot <= '0;
			s_q.cyc <= CYC_IDLE;
			s_q.active_rate <= `RST_CONV_RATE;
			s_q.win_cnt <= '0;
			s_q.low_cnt <= '0;
			s_q.seen_low <= 1'b0;
			s_q.rdata <= `RST_ZERO;
			s_q.pin_out <= 1'b0;
			s_q.pin_oe <= 1'b0;
			s_q.stall_out <= 1'b0;
			s_q.stall_oe <= 1'b0;
			s_q.ref_sel <= 1'b0;
			s_q.alert_q <= 1'b0;
			s_q.pct_alert <= 1'b0;
			s_q.boost <= 1'b0;
			s_q.avg <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign REG_RDATA = s_q.rdata;
	assign OVERTEMP_PIN_OUT = s_q.pin_out;
	assign OVERTEMP_PIN_OE = s_q.pin_oe;
	assign FAN_STALL_PIN_OUT = s_q.stall_out;
	assign FAN_STALL_PIN_OE = s_q.stall_oe;
	assign REF_INPUT_SEL = s_q.ref_sel;
	assign ALERT_QUEUED = s_q.alert_q;
	assign PCT_ALERT = s_q.pct_alert;
	assign FAN_BOOST = s_q.boost;
	assign ACTIVE_CONV_RATE = s_q.active_rate;
	assign AVERAGING_ON = s_q.avg;

	property p_stall;
		@(posedge CLK) disable iff (!rst_n)
		(|FAN_STALLED && !s_q.cfg4[`CFG4_REF_SEL]) |=> FAN_STALL_PIN_OE;
	endproperty
	a_stall: assert property (p_stall) else $error("stall pin not driven"); // [RL1]

	property p_ref;
		@(posedge CLK) disable iff (!rst_n)
		s_q.cfg4[`CFG4_REF_SEL] |=> !FAN_STALL_PIN_OE;
	endproperty
	a_ref: assert property (p_ref) else $error("stall pin driven in reference mode"); // [RL2]

	property p_clear;
		@(posedge CLK) disable iff (!rst_n)
		(ARA_DONE && !RESULT_VALID) |=> (s_q.chan_full == 3'b000) && !ALERT_QUEUED;
	endproperty
	a_clear: assert property (p_clear) else $error("queue not emptied"); // [RL7]

	property p_comp;
		@(posedge CLK) disable iff (!rst_n)
		(s_q.cfg1[`CFG1_COMP_MODE] && RESULT_VALID && RESULT_OUT_OF_LIMIT && RESULT_CHAN != 2'h3) |=> ALERT_QUEUED;
	endproperty
	a_comp: assert property (p_comp) else $error("comparator alert held back by queue"); // [RL3]

	property p_rate;
		@(posedge CLK) disable iff (!rst_n)
		!ROUND_ROBIN_END |=> $stable(ACTIVE_CONV_RATE);
	endproperty
	a_rate: assert property (p_rate) else $error("rate changed mid loop"); // [RL11]

	property p_avg;
		@(posedge CLK) disable iff (!rst_n)
		(ACTIVE_CONV_RATE >= `CONV_RATE_AVG_LIMIT) |=> !AVERAGING_ON;
	endproperty
	a_avg: assert property (p_avg) else $error("averaging at fast rate"); // [RL10]

	property p_boost;
		@(posedge CLK) disable iff (!rst_n)
		s_q.cfg2[`CFG2_BOOST_DIS] |=> !FAN_BOOST;
	endproperty
	a_boost: assert property (p_boost) else $error("boost while disabled"); // [RL14]

	property p_pin;
		@(posedge CLK) disable iff (!rst_n)
		(!s_q.cfg1[`CFG1_PIN_INPUT] && |s_q.overtemp_hot) |=> OVERTEMP_PIN_OE && !OVERTEMP_PIN_OUT;
	endproperty
	a_pin: assert property (p_pin) else $error("overtemp pin not low"); // [RL12]

	property p_input;
		@(posedge CLK) disable iff (!rst_n)
		(s_q.cfg1[`CFG1_PIN_INPUT] && s_q.cfg4[2:0] == 3'b000) |=> !OVERTEMP_PIN_OE;
	endproperty
	a_input: assert property (p_input) else $error("pin driven in input mode"); // [RL15]

	property p_mask;
		@(posedge CLK) disable iff (!rst_n)
		s_q.mask2[`MASK2_PCT] |=> !PCT_ALERT;
	endproperty
	a_mask: assert property (p_mask) else $error("masked percentage alert"); // [RL24]
endmodule

/* overtemp_wire_model.sv */
// open-drain overtemp wire with its pull-up and an external hot source
// assumes the device output enable means it sinks the line
`timescale 1ns/1ps
module overtemp_wire_model (
	input wire logic dev_oe,
	input wire logic ext_hot,
	output logic pin_level
);
	// pull-up wins unless some party sinks the line; never left floating
	assign pin_level = (dev_oe || ext_hot) ? 1'b0 : 1'b1;
endmodule

/* thermal_event_fault_queue_timer_tb.sv */
// self-checking bench for the thermal event block, register strobes driven directly
// assumes the register map header and a short window parameter for simulation
`timescale 1ns/1ps
`include "thermal_event_regs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
	$display("ERROR %0t got %h expected %h", $time, a, e); end end
module thermal_event_fault_queue_timer_tb;
	import thermal_event_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic ara_done = 1'b0;
	logic res_valid = 1'b0;
	logic [1:0] res_chan = 2'h0;
	logic res_ool = 1'b0;
	logic rr_end = 1'b0;
	logic [2:0] ot_above = 3'h0;
	logic [2:0] ot_below = 3'h7;
	logic [1:0] fan_stalled = 2'h0;
	logic ext_hot = 1'b0;
	logic pin, ot_out, ot_oe, fs_out, fs_oe, ref_sel, alert_q, pct_alert, boost, avg_on;
	logic [7:0] reg_rdata, act_rate, d;
	int errors = 0;
	int cmp_count = 0;

	thermal_event_fault_queue_timer #(.WIN_BASE_CYCLES(100)) i_thermal_event_fault_queue_timer (
		.CLK(clk), .RESETN(resetn), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .ARA_DONE(ara_done),
		.RESULT_VALID(res_valid), .RESULT_CHAN(res_chan), .RESULT_OUT_OF_LIMIT(res_ool),
		.ROUND_ROBIN_END(rr_end), .OVERTEMP_ABOVE(ot_above), .OVERTEMP_BELOW_HYST(ot_below),
		.FAN_STALLED(fan_stalled), .OVERTEMP_PIN_IN(pin), .OVERTEMP_PIN_OUT(ot_out),
		.OVERTEMP_PIN_OE(ot_oe), .FAN_STALL_PIN_OUT(fs_out), .FAN_STALL_PIN_OE(fs_oe),
		.REF_INPUT_SEL(ref_sel), .ALERT_QUEUED(alert_q), .PCT_ALERT(pct_alert),
		.FAN_BOOST(boost), .ACTIVE_CONV_RATE(act_rate), .AVERAGING_ON(avg_on));

	overtemp_wire_model i_overtemp_wire_model (.dev_oe(ot_oe), .ext_hot(ext_hot), .pin_level(pin));

	// free-running 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one write strobe, released at the next edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read strobe; data launched at the strobe edge is taken at the next edge, before a read clear shows
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask

	// one measurement result on a channel
	task automatic res(input logic [1:0] c, input logic o);
		@(posedge clk);
		res_valid <= 1'b1;
		res_chan <= c;
		res_ool <= o;
		@(posedge clk);
		res_valid <= 1'b0;
	endtask

	task automatic tally_and_finish;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		tick(2);
		resetn <= 1'b1;
		tick(3);
		`CHK(act_rate, `RST_CONV_RATE)
		`CHK(avg_on, 1'b1)
		`CHK(ot_oe, 1'b0)
		fan_stalled <= 2'h2;
		tick(3);
		`CHK(fs_oe, 1'b1)
		`CHK(fs_out, 1'b0)
		fan_stalled <= 2'h0;
		// every depth code, cleared alternately by ara and by a status read
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_FAULT_QUEUE, 8'(1 << i));
			for (int k = 0; k <= i; k++) begin
				tick(3);
				`CHK(alert_q, 1'b0)
				res(2'h1, 1'b1);
			end
			tick(3);
			`CHK(alert_q, 1'b1)
			if (i % 2 == 0) begin
				@(posedge clk);
				ara_done <= 1'b1;
				@(posedge clk);
				ara_done <= 1'b0;
			end else begin
				rd(`OFS_STATUS1, d);
			end
			tick(3);
			`CHK(alert_q, 1'b0)
		end
		// queues are per channel and count only consecutive readings
		wr(`OFS_FAULT_QUEUE, 8'h02);
		res(2'h0, 1'b1);
		res(2'h2, 1'b1);
		res(2'h0, 1'b0);
		res(2'h0, 1'b1);
		tick(3);
		`CHK(alert_q, 1'b0)
		res(2'h0, 1'b1);
		tick(3);
		`CHK(alert_q, 1'b1)
		// a mid-run reset empties the queues and restores defaults
		@(posedge clk);
		resetn <= 1'b0;
		tick(2);
		resetn <= 1'b1;
		tick(3);
		`CHK(alert_q, 1'b0)
		`CHK(act_rate, `RST_CONV_RATE)
		// comparator mode ignores the programmed depth and self-clears
		wr(`OFS_CFG1, 8'h08);
		wr(`OFS_FAULT_QUEUE, 8'h08);
		res(2'h1, 1'b1);
		tick(3);
		`CHK(alert_q, 1'b1)
		res(2'h1, 1'b0);
		tick(3);
		`CHK(alert_q, 1'b0)
		wr(`OFS_CFG1, 8'h00);
		// rate change waits for the loop end; a reserved code never lands
		wr(`OFS_CONV_RATE, 8'h09);
		tick(3);
		`CHK(act_rate, `RST_CONV_RATE)
		@(posedge clk);
		rr_end <= 1'b1;
		@(posedge clk);
		rr_end <= 1'b0;
		tick(3);
		`CHK(act_rate, 8'h09)
		`CHK(avg_on, 1'b0)
		wr(`OFS_CONV_RATE, 8'h0B);
		@(posedge clk);
		rr_end <= 1'b1;
		@(posedge clk);
		rr_end <= 1'b0;
		tick(3);
		`CHK(act_rate, 8'h09)
		// output mode with hysteresis and fan boost
		ot_above <= 3'h1;
		ot_below <= 3'h0;
		tick(3);
		`CHK(ot_oe, 1'b1)
		`CHK(ot_out, 1'b0)
		`CHK(boost, 1'b1)
		ot_above <= 3'h0;
		wr(`OFS_CFG2, 8'h02);
		tick(3);
		`CHK(boost, 1'b0)
		`CHK(ot_oe, 1'b1)
		ot_below <= 3'h7;
		tick(3);
		`CHK(ot_oe, 1'b0)
		// input mode, then local events re-enable the pull-down
		wr(`OFS_CFG1, 8'h04);
		ot_above <= 3'h1;
		ot_below <= 3'h0;
		tick(3);
		`CHK(ot_oe, 1'b0)
		wr(`OFS_CFG4, 8'h01);
		tick(3);
		`CHK(ot_oe, 1'b1)
		ot_above <= 3'h0;
		ot_below <= 3'h7;
		wr(`OFS_CFG4, 8'h80);
		fan_stalled <= 2'h3;
		tick(3);
		`CHK(ref_sel, 1'b1)
		`CHK(fs_oe, 1'b0)
		fan_stalled <= 2'h0;
		rd(`OFS_CFG4, d);
		`CHK(d, 8'h80)
		// let windows holding earlier lows close, then a clean one, then clear status
		tick(210);
		rd(`OFS_STATUS2, d);
		rd(`OFS_PCT_MEASURED, d);
		`CHK(d, 8'h00)
		`CHK(pct_alert, 1'b0)
		// zero limit alerts on the first low
		wr(`OFS_PCT_LIMIT, 8'h00);
		ext_hot <= 1'b1;
		tick(5);
		ext_hot <= 1'b0;
		for (int n = 0; n < 400 && pct_alert !== 1'b1; n++)
			@(posedge clk);
		`CHK(pct_alert, 1'b1)
		// masking hides the alert but the status bit stays set
		wr(`OFS_MASK2, 8'h10);
		tick(3);
		`CHK(pct_alert, 1'b0)
		rd(`OFS_STATUS2, d);
		`CHK(d[`STATUS2_PCT], 1'b1)
		wr(`OFS_MASK2, 8'h00);
		tick(110);
		rd(`OFS_STATUS2, d);
		// a nonzero limit is judged only when a window closes
		wr(`OFS_PCT_LIMIT, 8'h10);
		ext_hot <= 1'b1;
		tick(5);
		`CHK(pct_alert, 1'b0)
		tick(15);
		ext_hot <= 1'b0;
		for (int n = 0; n < 250 && pct_alert !== 1'b1; n++)
			@(posedge clk);
		`CHK(pct_alert, 1'b1)
		rd(`OFS_PCT_MEASURED, d);
		`CHK(d > 8'h10, 1'b1)
		tally_and_finish();
	end
endmodule
